// file: hdl/event_output_map.svh
`ifndef EVENT_OUTPUT_MAP_SVH
`define EVENT_OUTPUT_MAP_SVH
`define EV_ADDR_CFG0    8'h00
`define EV_ADDR_CFG1    8'h04
`define EV_ADDR_THR0    8'h08
`define EV_ADDR_THR1    8'h0c
`define EV_ADDR_OUTLVL  8'h10
`define EV_ADDR_ASSIGN  8'h14
`define EV_ADDR_STATUS  8'h18
`define EV_ADDR_ELAPSED 8'h1c
`define EV_CFG_SRC_LSB  0
`define EV_CFG_OUT_LSB  2
`define EV_CFG_LVL_BIT  5
`define EV_SRC_OFF      2'h0
`define EV_SRC_TIME     2'h1
`define EV_SRC_DIST     2'h2
`define EV_SRC_SPEED    2'h3
`define EV_TIME_MAX_MS  19'h7a120
`define EV_CLK_NS       8
`define EV_TICK_NS      1000000
`define EV_TICK_CYCLES  (`EV_TICK_NS / `EV_CLK_NS)
`endif

// file: hdl/event_output_pkg.sv
package event_output_pkg;
  typedef struct packed {
    logic [1:0][5:0]  cfg;
    logic [1:0][22:0] thr;
    logic [3:0]       lvl;
    logic [3:0][2:0]  asg;
    logic [16:0]      div;
    logic [18:0]      ms;
    logic [1:0]       fired;
    logic [3:0]       pin;
    logic [31:0]      rdata;
    logic             err;
  } state_t;
endpackage : event_output_pkg

// file: hdl/event_output_channel.sv
// Functional notes
// - two channels, each with target output 1 to 4 and level 0 or 1.
// - time source fires when elapsed milliseconds since motion start reach threshold.
// - distance source fires when travelled distance reaches threshold up to 8388607.
// - speed source fires when commanded speed reaches set point up to 500000 pps.
// - both channels armed together, each evaluated independently.
// - zero configuration deactivates the channel entirely.
// - a configured channel stays armed over any number of motions.
// - clearing a channel leaves its output level as it was.
// - every motion start restarts time, distance and firing of armed channels.
// - a met condition drives the target output to the configured level.
// - an output held by a system signal ignores all event changes.
// - system signal assignment 0 means none, 1 to 4 names the output.
//
// Added by the designer: the address map and the APB register port.
`include "event_output_map.svh"
module event_output_channel #(
  parameter int MS_CYCLES = `EV_TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        motion_start,
  input  wire logic [22:0] travel_dist,
  input  wire logic [18:0] cmd_speed,
  input  wire logic [3:0]  sys_signal,
  output logic [3:0]       general_out
);
  import event_output_pkg::*;

  state_t      s_q;
  state_t      s_d;
  logic        wr;
  logic        setup;
  logic [1:0]  cond;
  logic [1:0]  fire;
  logic [1:0]  tgt_ok;
  logic [1:0]  tgt_occ;
  logic [1:0][1:0] tidx;
  logic [3:0]  occ;
  logic [3:0]  sysl;
  logic        tick;

  assign pready  = 1'b1;
  assign prdata  = s_q.rdata;
  assign pslverr = s_q.err;
  assign general_out = s_q.pin;
  assign wr    = psel & penable & pwrite;
  assign setup = psel & ~penable;
  // millisecond tick from the cycle divider
  assign tick  = (s_q.div == 17'(MS_CYCLES - 1));

  // output occupancy from the system signal assignments
  always_comb begin
    occ  = 4'h0;
    sysl = 4'h0;
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) begin
        if (s_q.asg[k] == 3'(j + 1)) begin
          occ[j]  = 1'b1;
          sysl[j] = sys_signal[k];
        end
      end
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [1:0]  src;
    logic [2:0]  onum;
    logic        met;
    assign src  = s_q.cfg[i][`EV_CFG_SRC_LSB +: 2];
    assign onum = s_q.cfg[i][`EV_CFG_OUT_LSB +: 3];
    assign tidx[i]   = 2'(onum - 3'h1);
    assign tgt_ok[i] = (onum >= 3'h1) && (onum <= 3'h4);
    assign tgt_occ[i] = occ[tidx[i]];
    always_comb begin
      unique case (src)
        `EV_SRC_TIME:  met = ({4'h0, s_q.ms} >= s_q.thr[i]);
        `EV_SRC_DIST:  met = (travel_dist >= s_q.thr[i]);
        `EV_SRC_SPEED: met = ({4'h0, cmd_speed} >= s_q.thr[i]);
        default:       met = 1'b0;
      endcase
    end
    // each bit of cond has a single continuous driver
    assign cond[i] = met;
    // each channel judged alone, once per motion start or config write
    assign fire[i] = cond[i] & ~s_q.fired[i] & ~motion_start;
  end

  always_comb begin
    s_d = s_q;
    s_d.err = 1'b0;
    // elapsed time restarts with every motion
    if (motion_start) begin
      s_d.div = 17'h0;
      s_d.ms  = 19'h0;
    end else if (tick) begin
      s_d.div = 17'h0;
      if (s_q.ms != `EV_TIME_MAX_MS) begin
        s_d.ms = s_q.ms + 19'h1;
      end
    end else begin
      s_d.div = s_q.div + 17'h1;
    end
    if (wr) begin
      unique case (paddr)
        `EV_ADDR_CFG0: begin
          s_d.cfg[0]   = pwdata[5:0];
          s_d.fired[0] = 1'b0;
        end
        `EV_ADDR_CFG1: begin
          s_d.cfg[1]   = pwdata[5:0];
          s_d.fired[1] = 1'b0;
        end
        `EV_ADDR_THR0:   s_d.thr[0] = pwdata[22:0];
        `EV_ADDR_THR1:   s_d.thr[1] = pwdata[22:0];
        `EV_ADDR_OUTLVL: s_d.lvl    = pwdata[3:0];
        `EV_ADDR_ASSIGN: s_d.asg    = pwdata[11:0];
        default: ;
      endcase
    end
    if (motion_start) begin
      s_d.fired = 2'b00;
    end
    // channel two is applied last and wins a shared output
    for (int i = 0; i < 2; i++) begin
      if (fire[i]) begin
        s_d.fired[i] = 1'b1;
        if (tgt_ok[i] && !tgt_occ[i]) begin
          s_d.lvl[tidx[i]] = s_q.cfg[i][`EV_CFG_LVL_BIT];
        end
      end
    end
    for (int j = 0; j < 4; j++) begin
      s_d.pin[j] = occ[j] ? sysl[j] : s_d.lvl[j];
    end
    // read data latched in setup so it stands through the access phase
    if (setup) begin
      unique case (paddr)
        `EV_ADDR_CFG0:    s_d.rdata = {26'h0, s_q.cfg[0]};
        `EV_ADDR_CFG1:    s_d.rdata = {26'h0, s_q.cfg[1]};
        `EV_ADDR_THR0:    s_d.rdata = {9'h0, s_q.thr[0]};
        `EV_ADDR_THR1:    s_d.rdata = {9'h0, s_q.thr[1]};
        `EV_ADDR_OUTLVL:  s_d.rdata = {28'h0, s_q.lvl};
        `EV_ADDR_ASSIGN:  s_d.rdata = {20'h0, s_q.asg};
        `EV_ADDR_STATUS:  s_d.rdata = {22'h0, occ, s_q.pin, s_q.fired};
        `EV_ADDR_ELAPSED: s_d.rdata = {13'h0, s_q.ms};
        default:          s_d.rdata = 32'h0;
      endcase
    end
    // address error flagged for the access phase only
    if (psel && !penable) begin
      unique case (paddr)
        `EV_ADDR_CFG0, `EV_ADDR_CFG1, `EV_ADDR_THR0, `EV_ADDR_THR1,
        `EV_ADDR_OUTLVL, `EV_ADDR_ASSIGN, `EV_ADDR_STATUS,
        `EV_ADDR_ELAPSED: s_d.err = 1'b0;
        default:          s_d.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q       <= '0;
      // nothing fires before the first motion start or config write
      s_q.fired <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_DISABLED_SILENT: assert property (
    (s_q.cfg[0][1:0] == `EV_SRC_OFF) |-> !fire[0])
    else $error("disabled channel fired");
  AST_ONE_SHOT: assert property (
    s_q.fired[1] |-> !fire[1])
    else $error("channel fired twice in one motion");
  AST_RESTART: assert property (
    motion_start |=> (s_q.ms == 19'h0) && (s_q.fired == 2'b00))
    else $error("motion start did not restart evaluation");
  AST_TIME_FIRE: assert property (
    (g_ch[0].src == `EV_SRC_TIME) && !s_q.fired[0] && !motion_start
      && ({4'h0, s_q.ms} >= s_q.thr[0]) |-> fire[0])
    else $error("time condition missed");
  AST_DIST_FIRE: assert property (
    (g_ch[1].src == `EV_SRC_DIST) && !s_q.fired[1] && !motion_start
      && (travel_dist >= s_q.thr[1]) |=> s_q.fired[1])
    else $error("distance condition missed");
  AST_SPEED_FIRE: assert property (
    (g_ch[0].src == `EV_SRC_SPEED) && !s_q.fired[0] && !motion_start
      && ({4'h0, cmd_speed} < s_q.thr[0]) |-> !fire[0])
    else $error("speed fired below set point");
  AST_DRIVE_LEVEL: assert property (
    fire[0] && !fire[1] && tgt_ok[0] && !tgt_occ[0] && !wr
      |=> general_out[$past(tidx[0])] == $past(s_q.cfg[0][5]))
    else $error("event did not drive target level");
  AST_CLEAR_KEEPS: assert property (
    wr && (paddr == `EV_ADDR_CFG0) && (pwdata == 32'h0) && !fire[0] && !fire[1]
      |=> $stable(s_q.lvl) ##1 !fire[0])
    else $error("clearing changed output level");
  AST_ARMED_STAYS: assert property (
    motion_start && !wr |=> $stable(s_q.cfg))
    else $error("configuration lost across motion");
  for (genvar j = 0; j < 4; j++) begin : g_chk
    AST_SUPPRESS: assert property (
      occ[j] |=> general_out[j] == $past(sysl[j]))
      else $error("occupied output took event level");
  end

  // checks that mirror the ones above for the other channel
  AST_DISABLED_SILENT1: assert property (
    (s_q.cfg[1][1:0] == `EV_SRC_OFF) |-> !fire[1])
    else $error("disabled channel two fired");

  AST_ONE_SHOT0: assert property (
    s_q.fired[0] |-> !fire[0])
    else $error("channel one fired twice in one motion");

  // motion start, the millisecond counter and the source firing checks
  AST_START_QUIET: assert property (
    motion_start |-> (fire == 2'b00))
    else $error("channel fired on the motion start cycle");

  AST_START_DIV: assert property (
    motion_start |=> (s_q.div == 17'h0))
    else $error("motion start did not restart the divider");

  AST_MS_CEILING: assert property (
    s_q.ms <= `EV_TIME_MAX_MS)
    else $error("elapsed time ran past its ceiling");

  AST_MS_COUNT: assert property (
    tick && !motion_start && (s_q.ms != `EV_TIME_MAX_MS)
      |=> s_q.ms == $past(s_q.ms) + 19'h1)
    else $error("elapsed time did not advance on a tick");

  AST_TIME_EARLY1: assert property (
    (g_ch[1].src == `EV_SRC_TIME) && ({4'h0, s_q.ms} < s_q.thr[1])
      |-> !fire[1])
    else $error("time fired before threshold");

  AST_TIME_FIRE1: assert property (
    (g_ch[1].src == `EV_SRC_TIME) && !s_q.fired[1] && !motion_start
      && ({4'h0, s_q.ms} >= s_q.thr[1]) |=> s_q.fired[1])
    else $error("time condition missed on channel two");

  AST_DIST_FIRE0: assert property (
    (g_ch[0].src == `EV_SRC_DIST) && !s_q.fired[0] && !motion_start
      && (travel_dist >= s_q.thr[0]) |-> fire[0])
    else $error("distance condition missed on channel one");

  AST_DIST_EARLY0: assert property (
    (g_ch[0].src == `EV_SRC_DIST) && (travel_dist < s_q.thr[0])
      |-> !fire[0])
    else $error("distance fired before threshold");

  AST_SPEED_REACH0: assert property (
    (g_ch[0].src == `EV_SRC_SPEED) && !s_q.fired[0] && !motion_start
      && ({4'h0, cmd_speed} >= s_q.thr[0]) |-> fire[0])
    else $error("speed set point missed");

  AST_WR_REARM0: assert property (
    wr && (paddr == `EV_ADDR_CFG0) && !fire[0]
      |=> !s_q.fired[0])
    else $error("config write did not re-arm channel one");

  // level holding and suppression
  AST_DRIVE_LEVEL1: assert property (
    fire[1] && tgt_ok[1] && !tgt_occ[1]
      |=> general_out[$past(tidx[1])] == $past(s_q.cfg[1][`EV_CFG_LVL_BIT]))
    else $error("channel two did not drive target level");

  AST_CLEAR_KEEPS1: assert property (
    wr && (paddr == `EV_ADDR_CFG1) && (pwdata == 32'h0) && !fire[0] && !fire[1]
      |=> $stable(s_q.lvl))
    else $error("clearing channel two changed output level");

  AST_BLOCKED_KEEPS: assert property (
    fire[0] && tgt_occ[0] && !fire[1] && !(wr && (paddr == `EV_ADDR_OUTLVL))
      |=> $stable(s_q.lvl))
    else $error("blocked event changed output level");

  AST_MOTION_KEEPS_LEVEL: assert property (
    motion_start && !wr |=> $stable(s_q.lvl))
    else $error("motion start changed output level");

  COV_TIME_FIRE: cover property (fire[0] && (g_ch[0].src == `EV_SRC_TIME));
  COV_BOTH_FIRE: cover property (fire[0] ##[1:50] fire[1]);
  COV_BLOCKED:   cover property (fire[1] && tgt_occ[1]);
  COV_DIST_FIRE: cover property (fire[0] && (g_ch[0].src == `EV_SRC_DIST));
  COV_CLEAR:     cover property (wr && (paddr == `EV_ADDR_CFG0) && (pwdata == 32'h0));
endmodule : event_output_channel

// file: verification/motion_gen.sv
module motion_gen (
  input  wire logic        core_clk,
  input  wire logic        start_req,
  output logic             motion_start,
  output logic [22:0]      travel_dist,
  output logic [18:0]      cmd_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    motion_start = 1'b0;
    travel_dist = '0;
    cmd_speed = '0;
  end
  // one-cycle start pulse, then distance and speed ramp each cycle
  always @(posedge core_clk) begin
    motion_start <= start_req;
    travel_dist <= start_req ? 23'h0 : travel_dist + 23'h1;
    cmd_speed <= start_req ? 19'h0 : cmd_speed + 19'h1;
  end
endmodule : motion_gen

// file: verification/tb_top.sv
`include "event_output_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, resetn, psel, penable, pwrite, start_req;
  logic        pready, pslverr, motion_start, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [22:0] travel_dist;
  logic [18:0] cmd_speed;
  logic [3:0]  sys_signal, general_out;
  int          mismatches, n_compared, cycles;
  event_output_channel #(.MS_CYCLES(10)) u_dut (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .motion_start(motion_start),
    .travel_dist(travel_dist), .cmd_speed(cmd_speed), .sys_signal(sys_signal),
    .general_out(general_out));
  motion_gen u_gen (.core_clk(core_clk), .start_req(start_req), .motion_start(motion_start),
    .travel_dist(travel_dist), .cmd_speed(cmd_speed));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic motion(input int n);
    start_req <= 1'b1;
    @(posedge core_clk);
    start_req <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask : motion
  task automatic t_dist();
    apb(1, `EV_ADDR_OUTLVL, 32'h0);
    apb(1, `EV_ADDR_THR0, 32'h14);
    apb(1, `EV_ADDR_CFG0, 32'h2a);
    motion(10);
    chk("dist early", general_out, 32'h0);
    repeat (20) @(posedge core_clk);
    chk("dist fire", general_out, 32'h2);
    apb(1, `EV_ADDR_OUTLVL, 32'h0);
    repeat (10) @(posedge core_clk);
    chk("no refire", general_out, 32'h0);
  endtask : t_dist
  task automatic t_rearm();
    motion(30);
    chk("next motion", general_out, 32'h2);
    apb(1, `EV_ADDR_CFG0, 32'h0);
    @(posedge core_clk);
    chk("clear keeps", general_out, 32'h2);
    apb(1, `EV_ADDR_OUTLVL, 32'h0);
    motion(30);
    chk("cleared idle", general_out, 32'h0);
  endtask : t_rearm
  task automatic t_both();
    apb(1, `EV_ADDR_THR0, 32'hf);
    apb(1, `EV_ADDR_CFG0, 32'h27);
    apb(1, `EV_ADDR_THR1, 32'h3);
    apb(1, `EV_ADDR_CFG1, 32'h31);
    apb(1, `EV_ADDR_OUTLVL, 32'h0);
    motion(10);
    chk("both early", general_out, 32'h0);
    repeat (40) @(posedge core_clk);
    chk("both fire", general_out, 32'h9);
    apb(0, `EV_ADDR_STATUS, 32'h0);
    chk("fired", rd & 32'h3, 32'h3);
    chk("status pins", (rd >> 2) & 32'hf, 32'h9);
    apb(0, `EV_ADDR_CFG1, 32'h0);
    chk("cfg1 back", rd, 32'h31);
  endtask : t_both
  task automatic t_block();
    apb(1, `EV_ADDR_ASSIGN, 32'h1);
    apb(1, `EV_ADDR_OUTLVL, 32'h0);
    motion(50);
    chk("occupied", general_out, 32'h8);
    sys_signal <= 4'h1;
    repeat (3) @(posedge core_clk);
    chk("sys level", general_out, 32'h9);
    apb(1, `EV_ADDR_CFG1, 32'h0);
    @(posedge core_clk);
    chk("clear two keeps", general_out, 32'h9);
  endtask : t_block
  task automatic t_err();
    apb(0, 8'h40, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask : t_err
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    start_req = 1'b0;
    sys_signal = '0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    t_dist();
    t_rearm();
    t_both();
    t_block();
    t_err();
    complete_run();
  end
endmodule : tb_top
